// *** rtl/dic_pkg.sv ***
// Purpose: Constants, register map and states for the DRAM interface control block
// Assumes: 100 MHz system clock, 16-bit register port
// Notes: Offsets and field positions here are used by the logic; the bench shares only the strobe timing constants
package dic_pkg;
    localparam logic [3:0] DIC_OFF_DRAM = 4'h0;
    localparam logic [3:0] DIC_OFF_PAR = 4'h2;
    localparam logic [3:0] DIC_OFF_RFSH = 4'h4;
    localparam int DIC_B_STROBE = 15;
    localparam int DIC_B_RHOLD = 14;
    localparam int DIC_B_PRE = 13;
    localparam int DIC_B_BURST = 12;
    localparam int DIC_B_DUTY = 11;
    localparam int DIC_B_MUX = 10;
    localparam int DIC_B_SHIFT = 8;
    localparam int DIC_B_PEF = 15;
    localparam int DIC_B_FORCED_PARITY_OUT = 14;
    localparam int DIC_B_PODD = 13;
    localparam int DIC_B_PSCOPE = 11;
    localparam int DIC_B_RON = 7;
    localparam int DIC_B_RKIND = 6;
    localparam int DIC_B_RWAIT = 4;
    localparam logic [15:0] DIC_DRAM_MASK = 16'hff00;
    localparam logic [15:0] DIC_PAR_MASK = 16'h7800;
    localparam logic [15:0] DIC_RFSH_MASK = 16'h00f0;
    localparam logic [15:0] DIC_RST_VAL = 16'h0000;
    localparam int DIC_SHIFT_BASE = 8;
    localparam logic [1:0] DIC_SCOPE_DRAM = 2'h1;
    localparam logic [1:0] DIC_SCOPE_AREA2 = 2'h2;
    localparam int DIC_CAS_PERIOD = 20;
    localparam int DIC_DUTY_WIDE_PCT = 50;
    localparam int DIC_DUTY_NARROW_PCT = 35;
    localparam logic [4:0] DIC_HI_WIDE = 5'(DIC_CAS_PERIOD * DIC_DUTY_WIDE_PCT / 100);
    localparam logic [4:0] DIC_HI_NARROW = 5'(DIC_CAS_PERIOD * DIC_DUTY_NARROW_PCT / 100);
    localparam logic [4:0] DIC_LO_WIDE = 5'(DIC_CAS_PERIOD) - DIC_HI_WIDE;
    localparam logic [4:0] DIC_LO_NARROW = 5'(DIC_CAS_PERIOD) - DIC_HI_NARROW;
    localparam logic [4:0] DIC_PRE_SHORT = 5'h01;
    localparam logic [4:0] DIC_PRE_LONG = 5'h02;
    typedef enum logic [2:0] {
        DIC_IDLE = 3'h0,
        DIC_ROW = 3'h1,
        DIC_COL = 3'h3,
        DIC_CHI = 3'h2,
        DIC_PRE = 3'h6,
        DIC_RFC = 3'h7,
        DIC_RFW = 3'h5,
        DIC_SLF = 3'h4
    } dic_state_e;
endpackage : dic_pkg

// *** rtl/dic_top.sv ***
// Purpose: DRAM strobe sequencing, address multiplexing, parity and refresh
// Assumes: All inputs synchronous to sys_clk_i; one access request held until ack
// Notes: Column strobe period is DIC_CAS_PERIOD system cycles
`timescale 1ns/100ps
`default_nettype none
module dic_top #(
    parameter int AW = 28,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Access requests
    input wire logic req_i,
    input wire logic req_wr_i,
    input wire logic req_area2_i,
    input wire logic [1:0] req_be_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [DW-1:0] req_wdata_i,
    input wire logic refresh_req_i,
    output logic ack_o,
    output logic [DW-1:0] rdata_o,
    // DRAM pins
    output logic ras_n_o,
    output logic col_strobe_high_n_o,
    output logic col_strobe_low_n_o,
    output logic wr_n_o,
    output logic write_strobe_high_n_o,
    output logic write_strobe_low_n_o,
    output logic [AW-1:0] dram_addr_o,
    output logic [DW-1:0] dram_wdata_o,
    output logic dram_data_oe_o,
    output logic parity_o,
    input wire logic [DW-1:0] dram_rdata_i,
    input wire logic parity_i,
    input wire logic wait_i
);
    import dic_pkg::*;

    logic [15:0] dram_config_r, parity_config_r, refresh_config_r;
    logic pef_seen_r, rfsh_pend_r;
    dic_state_e state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic row_open_r;
    logic [AW-1:0] row_r;
    logic [1:0] shift;
    logic [AW-1:0] row_of_req;
    logic par_scope, par_want, par_bad, done_col, rfsh_go, req_ok;

    assign shift = dram_config_r[DIC_B_SHIFT +: 2];
    // Code 11 is left to software to avoid; it falls back to the widest shift
    assign row_of_req = req_addr_i >> (DIC_SHIFT_BASE + ((shift == 2'h3) ? 2 : int'(shift)));
    assign par_scope = (parity_config_r[DIC_B_PSCOPE +: 2] == DIC_SCOPE_DRAM && !req_area2_i)
        || (parity_config_r[DIC_B_PSCOPE +: 2] == DIC_SCOPE_AREA2);
    assign par_want = (^req_wdata_i) ^ parity_config_r[DIC_B_PODD];
    assign par_bad = par_scope && !req_wr_i && ((^{dram_rdata_i, parity_i}) != parity_config_r[DIC_B_PODD]);
    assign done_col = (state_r == DIC_CHI) && (cnt_r == 5'h01);
    assign rfsh_go = rfsh_pend_r && refresh_config_r[DIC_B_RON];
    // A request still held while its ack stands is not taken a second time
    assign req_ok = req_i && !ack_o;

    // Register writes
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dram_config_r <= DIC_RST_VAL;
            refresh_config_r <= DIC_RST_VAL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == DIC_OFF_DRAM) begin
                dram_config_r <= reg_wdata_i & DIC_DRAM_MASK;
            end
            if (reg_addr_i == DIC_OFF_RFSH) begin
                refresh_config_r <= reg_wdata_i & DIC_RFSH_MASK;
            end
        end
    end

    // Parity register; an error in the clearing cycle wins
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            parity_config_r <= DIC_RST_VAL;
            pef_seen_r <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == DIC_OFF_PAR) begin
                parity_config_r[DIC_B_FORCED_PARITY_OUT:DIC_B_PSCOPE] <= reg_wdata_i[DIC_B_FORCED_PARITY_OUT:DIC_B_PSCOPE];
            end
            if (state_r == DIC_COL && cnt_r == 5'h01 && !wait_i && par_bad) begin
                parity_config_r[DIC_B_PEF] <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == DIC_OFF_PAR && !reg_wdata_i[DIC_B_PEF] && pef_seen_r) begin
                parity_config_r[DIC_B_PEF] <= 1'b0;
            end
            if (reg_rd_i && reg_addr_i == DIC_OFF_PAR && parity_config_r[DIC_B_PEF]) begin
                pef_seen_r <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == DIC_OFF_PAR) begin
                pef_seen_r <= 1'b0;
            end
        end
    end

    // Register reads
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                DIC_OFF_DRAM: reg_rdata_o <= dram_config_r;
                DIC_OFF_PAR: reg_rdata_o <= parity_config_r;
                DIC_OFF_RFSH: reg_rdata_o <= refresh_config_r;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Refresh request latch; refresh off drops any pending request
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rfsh_pend_r <= 1'b0;
        end else if (refresh_req_i && refresh_config_r[DIC_B_RON]) begin
            rfsh_pend_r <= 1'b1;
        end else if (state_r == DIC_RFC || !refresh_config_r[DIC_B_RON]) begin
            rfsh_pend_r <= 1'b0;
        end
    end

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r > 5'h00) ? cnt_r - 5'h01 : 5'h00;
        case (state_r)
            DIC_IDLE: begin
                if (rfsh_go) begin
                    state_nxt = row_open_r ? DIC_PRE : DIC_RFC;
                    cnt_nxt = dram_config_r[DIC_B_PRE] ? DIC_PRE_LONG : DIC_PRE_SHORT;
                end else if (req_ok && row_open_r && dram_config_r[DIC_B_BURST] && row_of_req == row_r) begin
                    state_nxt = DIC_COL;
                    cnt_nxt = dram_config_r[DIC_B_DUTY] ? DIC_LO_NARROW : DIC_LO_WIDE;
                end else if (req_ok && row_open_r) begin
                    state_nxt = DIC_PRE;
                    cnt_nxt = dram_config_r[DIC_B_PRE] ? DIC_PRE_LONG : DIC_PRE_SHORT;
                end else if (req_ok) begin
                    state_nxt = DIC_ROW;
                    cnt_nxt = 5'h01;
                end
            end
            DIC_ROW: begin
                state_nxt = DIC_COL;
                cnt_nxt = dram_config_r[DIC_B_DUTY] ? DIC_LO_NARROW : DIC_LO_WIDE;
            end
            DIC_COL: begin
                if (cnt_r <= 5'h01 && !wait_i) begin
                    state_nxt = DIC_CHI;
                    cnt_nxt = dram_config_r[DIC_B_DUTY] ? DIC_HI_NARROW : DIC_HI_WIDE;
                end else if (cnt_r <= 5'h01) begin
                    cnt_nxt = 5'h01;
                end
            end
            DIC_CHI: begin
                if (cnt_r == 5'h01) begin
                    // Without burst the row is closed so the next access is a full one
                    if (dram_config_r[DIC_B_RHOLD] && dram_config_r[DIC_B_BURST]) begin
                        state_nxt = DIC_IDLE;
                    end else begin
                        state_nxt = DIC_PRE;
                        cnt_nxt = dram_config_r[DIC_B_PRE] ? DIC_PRE_LONG : DIC_PRE_SHORT;
                    end
                end
            end
            DIC_PRE: begin
                if (cnt_r == 5'h01) begin
                    state_nxt = rfsh_go ? DIC_RFC : DIC_IDLE;
                end
            end
            DIC_RFC: begin
                state_nxt = refresh_config_r[DIC_B_RKIND] ? DIC_SLF : DIC_RFW;
                cnt_nxt = 5'(refresh_config_r[DIC_B_RWAIT +: 2]) + 5'h01;
            end
            DIC_RFW: begin
                if (cnt_r == 5'h01) begin
                    state_nxt = DIC_PRE;
                    cnt_nxt = dram_config_r[DIC_B_PRE] ? DIC_PRE_LONG : DIC_PRE_SHORT;
                end
            end
            DIC_SLF: begin
                if (!(refresh_config_r[DIC_B_RON] && refresh_config_r[DIC_B_RKIND])) begin
                    state_nxt = DIC_PRE;
                    cnt_nxt = dram_config_r[DIC_B_PRE] ? DIC_PRE_LONG : DIC_PRE_SHORT;
                end
            end
            default: state_nxt = DIC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= DIC_IDLE;
            cnt_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Open row tracking for page-mode hits
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            row_open_r <= 1'b0;
            row_r <= '0;
        end else begin
            if (state_r == DIC_ROW) begin
                row_open_r <= 1'b1;
                row_r <= row_of_req;
            end else if (state_r == DIC_PRE) begin
                row_open_r <= 1'b0;
            end
        end
    end

    // Pin drive, registered from the next state
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ras_n_o <= 1'b1;
            col_strobe_high_n_o <= 1'b1;
            col_strobe_low_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            write_strobe_high_n_o <= 1'b1;
            write_strobe_low_n_o <= 1'b1;
        end else begin
            ras_n_o <= !(state_nxt inside {DIC_ROW, DIC_COL, DIC_CHI, DIC_RFW, DIC_SLF}
                || (state_nxt == DIC_IDLE && row_open_r && state_r != DIC_PRE)
                || (state_nxt == DIC_IDLE && state_r == DIC_CHI));
            if (state_nxt inside {DIC_RFC, DIC_RFW, DIC_SLF}) begin
                col_strobe_high_n_o <= dram_config_r[DIC_B_STROBE];
                col_strobe_low_n_o <= 1'b0;
                wr_n_o <= 1'b1;
                write_strobe_high_n_o <= 1'b1;
                write_strobe_low_n_o <= 1'b1;
            end else if (state_nxt == DIC_COL) begin
                if (dram_config_r[DIC_B_STROBE]) begin
                    col_strobe_high_n_o <= 1'b1;
                    col_strobe_low_n_o <= 1'b0;
                    wr_n_o <= 1'b1;
                    write_strobe_high_n_o <= !(req_wr_i && req_be_i[1]);
                    write_strobe_low_n_o <= !(req_wr_i && req_be_i[0]);
                end else begin
                    col_strobe_high_n_o <= !req_be_i[1];
                    col_strobe_low_n_o <= !req_be_i[0];
                    wr_n_o <= !req_wr_i;
                    write_strobe_high_n_o <= 1'b1;
                    write_strobe_low_n_o <= 1'b1;
                end
            end else begin
                col_strobe_high_n_o <= 1'b1;
                col_strobe_low_n_o <= 1'b1;
                wr_n_o <= 1'b1;
                write_strobe_high_n_o <= 1'b1;
                write_strobe_low_n_o <= 1'b1;
            end
        end
    end

    // Address, data and parity drive
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dram_addr_o <= '0;
            dram_wdata_o <= '0;
            dram_data_oe_o <= 1'b0;
            parity_o <= 1'b0;
        end else begin
            if (dram_config_r[DIC_B_MUX] && state_nxt == DIC_ROW) begin
                dram_addr_o <= row_of_req;
            end else begin
                dram_addr_o <= req_addr_i;
            end
            dram_wdata_o <= req_wdata_i;
            dram_data_oe_o <= req_wr_i && state_nxt == DIC_COL;
            if (parity_config_r[DIC_B_FORCED_PARITY_OUT]) begin
                parity_o <= 1'b1;
            end else begin
                parity_o <= par_scope && req_wr_i && par_want;
            end
        end
    end

    // Access completion and read capture
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o <= 1'b0;
            rdata_o <= '0;
        end else begin
            ack_o <= done_col;
            if (state_r == DIC_COL && cnt_r == 5'h01 && !wait_i && !req_wr_i) begin
                rdata_o <= dram_rdata_i;
            end
        end
    end

    // Checks
    sequence cbr_start_s;
        state_r == DIC_RFC && !refresh_config_r[DIC_B_RKIND] && refresh_config_r[DIC_B_RWAIT +: 2] == 2'h0;
    endsequence
    pre_short_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_r != DIC_PRE && state_nxt == DIC_PRE && !dram_config_r[DIC_B_PRE]
        |=> state_r == DIC_PRE ##1 state_r != DIC_PRE)
        else $error("precharge not one cycle");
    pre_long_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_r != DIC_PRE && state_nxt == DIC_PRE && dram_config_r[DIC_B_PRE]
        |=> state_r == DIC_PRE [*2] ##1 state_r != DIC_PRE)
        else $error("precharge not two cycles");
    cbr_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        cbr_start_s |=> state_r == DIC_RFW ##1 state_r == DIC_PRE)
        else $error("refresh wait wrong");
    duty_wide_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_r == DIC_COL && state_nxt == DIC_CHI && !dram_config_r[DIC_B_DUTY] |=> cnt_r == DIC_HI_WIDE)
        else $error("wide duty wrong");
    duty_narrow_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_r == DIC_COL && state_nxt == DIC_CHI && dram_config_r[DIC_B_DUTY] |=> cnt_r == DIC_HI_NARROW)
        else $error("narrow duty wrong");
    ras_up_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        done_col && !dram_config_r[DIC_B_RHOLD] |=> ras_n_o)
        else $error("row strobe not raised");
    strobe_arr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        dram_config_r[DIC_B_STROBE] && $stable(dram_config_r) |-> col_strobe_high_n_o && wr_n_o)
        else $error("strobe arrangement broken");
    forced_par_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        parity_config_r[DIC_B_FORCED_PARITY_OUT] && $past(parity_config_r[DIC_B_FORCED_PARITY_OUT]) |-> parity_o)
        else $error("parity not forced");
    pef_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        parity_config_r[DIC_B_PEF] && !pef_seen_r |=> parity_config_r[DIC_B_PEF])
        else $error("error flag cleared without read");
    no_rfsh_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        !refresh_config_r[DIC_B_RON] && state_r == DIC_IDLE |=> state_r != DIC_RFC)
        else $error("refresh while disabled");
endmodule : dic_top
`default_nettype wire

// *** sim/dic_dram_model.sv ***
// Purpose: Behavioural DRAM array on the far side of the strobe pins
// Assumes: Column address equals the byte address while column strobes are low
// Notes: Outside reads the data lines toggle, so a stale value never looks valid
`timescale 1ns/100ps
`default_nettype none
module dic_dram_model (
    // Clock
    input wire logic sys_clk_i,
    // Strobes, address and write side
    input wire logic ras_n_i,
    input wire logic cas_hi_n_i,
    input wire logic cas_lo_n_i,
    input wire logic wr_n_i,
    input wire logic wsh_n_i,
    input wire logic wsl_n_i,
    input wire logic [27:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic par_wr_i,
    // Fault injection
    input wire logic bad_par_i,
    // Read side
    output logic [15:0] data_o,
    output logic par_rd_o
);
    logic [15:0] mem [256];
    logic pmem [256];
    logic hi_w;
    logic lo_w;
    logic rd_on;
    assign hi_w = (!cas_hi_n_i && !wr_n_i) || !wsh_n_i;
    assign lo_w = (!cas_lo_n_i && !wr_n_i) || !wsl_n_i;
    assign rd_on = !ras_n_i && (!cas_hi_n_i || !cas_lo_n_i) && !hi_w && !lo_w;
    // Byte lanes follow whichever strobe scheme is active
    always @(posedge sys_clk_i) begin
        if (hi_w) mem[addr_i[8:1]][15:8] <= wdata_i[15:8];
        if (lo_w) mem[addr_i[8:1]][7:0] <= wdata_i[7:0];
        if (hi_w || lo_w) pmem[addr_i[8:1]] <= par_wr_i;
        if (rd_on) begin
            data_o <= mem[addr_i[8:1]];
            par_rd_o <= pmem[addr_i[8:1]] ^ bad_par_i;
        end else begin
            data_o <= ~data_o;
            par_rd_o <= ~par_rd_o;
        end
    end
endmodule : dic_dram_model
`default_nettype wire

// *** sim/dic_top_tb.sv ***
// Purpose: Self-checking bench for the DRAM interface control block
// Assumes: Partner array answers reads while column strobes are low
// Notes: Expected words are queued in write order and popped on read back
`timescale 1ns/100ps
`default_nettype none
module dic_top_tb;
    import dic_pkg::*;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic req_i = 1'b0;
    logic req_wr_i = 1'b0;
    logic req_area2_i = 1'b0;
    logic [1:0] req_be_i = 2'h0;
    logic [27:0] req_addr_i = 28'h0000000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic refresh_req_i = 1'b0;
    logic wait_i = 1'b0;
    logic bad = 1'b0;
    logic ras_p = 1'b1;
    logic [15:0] reg_rdata_o, rdata_o, dram_wdata_o, dram_rdata_i, q, d, e;
    logic ack_o, ras_n_o, col_strobe_high_n_o, col_strobe_low_n_o, wr_n_o, gpar, parity_o, parity_i;
    logic write_strobe_high_n_o, write_strobe_low_n_o, dram_data_oe_o;
    logic [27:0] dram_addr_o, raddr, a;
    logic [4:0] mw;
    logic [15:0] eq [$];
    int errors = 0;
    int n_tests = 0;
    int ncl, nfall, nrc, noe, n, s, c, g0;
    time tack, t1;
    always #5 sys_clk_i = ~sys_clk_i;
    dic_top dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .req_i, .req_wr_i, .req_area2_i, .req_be_i, .req_addr_i, .req_wdata_i, .refresh_req_i, .ack_o,
        .rdata_o, .ras_n_o, .col_strobe_high_n_o, .col_strobe_low_n_o, .wr_n_o, .write_strobe_high_n_o,
        .write_strobe_low_n_o, .dram_addr_o, .dram_wdata_o, .dram_data_oe_o, .parity_o, .dram_rdata_i,
        .parity_i, .wait_i);
    dic_dram_model mdl (.sys_clk_i, .ras_n_i(ras_n_o), .cas_hi_n_i(col_strobe_high_n_o),
        .cas_lo_n_i(col_strobe_low_n_o), .wr_n_i(wr_n_o), .wsh_n_i(write_strobe_high_n_o),
        .wsl_n_i(write_strobe_low_n_o), .addr_i(dram_addr_o), .wdata_i(dram_wdata_o), .par_wr_i(parity_o),
        .bad_par_i(bad), .data_o(dram_rdata_i), .par_rd_o(parity_i));
    // Pins are watched mid-cycle where every registered output has settled
    always @(negedge sys_clk_i) begin
        if (!col_strobe_low_n_o) ncl++;
        if (!ras_n_o && !col_strobe_low_n_o) nrc++;
        if (ras_p && !ras_n_o) begin
            nfall++;
            raddr = dram_addr_o;
        end
        mw = mw & {wr_n_o, write_strobe_high_n_o, write_strobe_low_n_o, col_strobe_high_n_o, col_strobe_low_n_o};
        if (!(wr_n_o && write_strobe_high_n_o && write_strobe_low_n_o)) gpar = parity_o;
        // Data drive must follow the write strobes exactly
        if ((wr_n_o && write_strobe_high_n_o && write_strobe_low_n_o) == dram_data_oe_o) noe++;
        ras_p = ras_n_o;
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic report_and_stop;
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task automatic rwr(input logic [3:0] ad, input logic [15:0] wd);
        @(posedge sys_clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= wd;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : rwr
    task automatic rrd(input logic [3:0] ad);
        @(posedge sys_clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 q = reg_rdata_o;
    endtask : rrd
    task automatic acc(input logic w, input logic [1:0] b, input logic [27:0] ad, input logic [15:0] wd,
                       input logic a2, input logic bp);
        int i;
        @(posedge sys_clk_i);
        req_i <= 1'b1;
        req_wr_i <= w;
        req_be_i <= b;
        req_addr_i <= ad;
        req_wdata_i <= wd;
        req_area2_i <= a2;
        bad <= bp;
        ncl = 0;
        nfall = 0;
        nrc = 0;
        noe = 0;
        mw = 5'h1f;
        for (i = 0; i < 300 && ack_o !== 1'b1; i++) begin
            @(posedge sys_clk_i);
        end
        req_i <= 1'b0;
        q = rdata_o;
        t1 = tack;
        tack = $time;
        chk("ack", 1, i < 300);
    endtask : acc
    task automatic rfsh(input logic [15:0] cfg, input int cyc);
        rwr(4'h4, cfg);
        @(posedge sys_clk_i);
        refresh_req_i <= 1'b1;
        wait_i <= 1'b1;
        nrc = 0;
        @(posedge sys_clk_i);
        refresh_req_i <= 1'b0;
        repeat (cyc) @(posedge sys_clk_i);
        wait_i <= 1'b0;
    endtask : rfsh
    initial begin
        // Tests take some 1.6k cycles; the 30k-cycle limit allows over fifteen times that
        #300000;
        errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h53920bab));
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        for (n = 0; n < 4; n++) begin
            rrd(4'(2 * n));
            chk("reset_value", 0, q);
        end
        rwr(4'h0, 16'hfeff);
        rrd(4'h0);
        chk("dram_config", 16'hfe00, q);
        rwr(4'h2, 16'hf7ff);
        rrd(4'h2);
        chk("parity_config", 16'h7000, q);
        rwr(4'h4, 16'hffff);
        rrd(4'h4);
        chk("refresh_config", 16'h00f0, q);
        rwr(4'h6, 16'hffff);
        rrd(4'h6);
        chk("unmapped", 0, q);
        rwr(4'h2, 16'h0000);
        rwr(4'h4, 16'h0000);
        for (n = 0; n < 6; n++) begin
            s = n / 3;
            rwr(4'h0, 16'(s << 15));
            d = 16'($urandom);
            a = 28'h0000010 + 28'(4 * n);
            acc(1'b1, 2'h3, a, ~d, 1'b0, 1'b0);
            acc(1'b1, 2'(n % 3 + 1), a, d, 1'b0, 1'b0);
            e = ~d;
            if (req_be_i[1]) e[15:8] = d[15:8];
            if (req_be_i[0]) e[7:0] = d[7:0];
            eq.push_back(e);
            chk("wr_n", s, mw[4]);
            chk("wstrobe_hi", !(s && req_be_i[1]), mw[3]);
            chk("wstrobe_lo", !(s && req_be_i[0]), mw[2]);
            chk("cstrobe_hi", s || !req_be_i[1], mw[1]);
            chk("cstrobe_lo", !s && !req_be_i[0], mw[0]);
            chk("data_oe", 0, noe);
        end
        for (n = 0; n < 6; n++) begin
            rwr(4'h0, 16'((n % 2) << 11));
            acc(1'b0, 2'h3, 28'h0000010 + 28'(4 * n), 16'h0000, 1'b0, 1'b0);
            chk("read_data", eq.pop_front(), q);
            s = 100 - ((n % 2) ? DIC_DUTY_NARROW_PCT : DIC_DUTY_WIDE_PCT);
            chk("cas_low", DIC_CAS_PERIOD * s / 100, ncl);
            chk("data_oe", 0, noe);
        end
        // Row held open, so the precharge falls inside the second access
        for (n = 0; n < 2; n++) begin
            rwr(4'h0, 16'h5000 | 16'(n << 13));
            acc(1'b0, 2'h3, 28'h0000010, 16'h0000, 1'b0, 1'b0);
            acc(1'b0, 2'h3, 28'h0100010, 16'h0000, 1'b0, 1'b0);
            if (n == 1) chk("precharge", g0 + 1, int'((tack - t1) / 10));
            g0 = int'((tack - t1) / 10);
        end
        for (c = 0; c < 3; c++) begin
            rwr(4'h0, 16'h5000 | 16'(c << 8));
            a = 28'h0123400;
            acc(1'b0, 2'h3, a, 16'h0000, 1'b0, 1'b0);
            acc(1'b0, 2'h3, a ^ (28'h1 << (7 + c)), 16'h0000, 1'b0, 1'b0);
            chk("page_hit", 0, nfall);
            acc(1'b0, 2'h3, a ^ (28'h1 << (8 + c)), 16'h0000, 1'b0, 1'b0);
            chk("page_miss", 1, nfall);
        end
        rwr(4'h0, 16'h1000);
        acc(1'b0, 2'h3, a, 16'h0000, 1'b0, 1'b0);
        acc(1'b0, 2'h3, a, 16'h0000, 1'b0, 1'b0);
        chk("row_release", 1, nfall);
        for (c = 0; c < 4; c++) begin
            rwr(4'h0, (c < 3) ? (16'h0400 | 16'(c << 8)) : 16'h0000);
            a = 28'($urandom);
            acc(1'b0, 2'h3, a, 16'h0000, 1'b0, 1'b0);
            chk("row_addr", (c < 3) ? (a >> (8 + c)) : a, raddr);
        end
        rwr(4'h0, 16'h0000);
        rwr(4'h2, 16'h0800);
        d = 16'($urandom);
        acc(1'b1, 2'h3, 28'h0000040, d, 1'b0, 1'b0);
        chk("parity_even", ^d, gpar);
        acc(1'b0, 2'h3, 28'h0000040, 16'h0000, 1'b0, 1'b0);
        rrd(4'h2);
        chk("flag_clean", 0, q[15]);
        acc(1'b0, 2'h3, 28'h0000040, 16'h0000, 1'b0, 1'b1);
        rwr(4'h2, 16'h0800);
        rrd(4'h2);
        chk("flag_kept", 1, q[15]);
        rwr(4'h2, 16'h0800);
        rrd(4'h2);
        chk("flag_clear", 0, q[15]);
        for (n = 0; n < 3; n++) begin
            rwr(4'h2, (n == 0) ? 16'h0000 : (n == 1) ? 16'h0800 : 16'h1000);
            acc(1'b0, 2'h3, 28'h0000040, 16'h0000, n > 0, 1'b1);
            rrd(4'h2);
            chk("flag_scope", n == 2, q[15]);
            rrd(4'h2);
            rwr(4'h2, 16'h0000);
        end
        rwr(4'h2, 16'h2800);
        d = 16'($urandom);
        acc(1'b1, 2'h3, 28'h0000044, d, 1'b0, 1'b0);
        chk("parity_odd", ~^d, gpar);
        rwr(4'h2, 16'h4000);
        acc(1'b1, 2'h3, 28'h0000048, 16'h0003, 1'b0, 1'b0);
        chk("parity_forced", 1, gpar);
        for (c = 0; c < 4; c++) begin
            rfsh(16'h0080 | 16'(c << 4), 60);
            chk("cbr_wait", c + 1, nrc);
        end
        rfsh(16'h0000, 30);
        chk("refresh_off", 0, nrc);
        rfsh(16'h00c0, 30);
        chk("self_refresh", 0, ras_n_o);
        rwr(4'h4, 16'h0000);
        repeat (30) @(posedge sys_clk_i);
        chk("self_exit", 1, ras_n_o);
        report_and_stop();
    end
endmodule : dic_top_tb
`default_nettype wire
